// ===== inc/pds_pkg.sv
// Shared constants, encodings and helper functions for the PLL divider and input select block.
package pds_pkg;

    // Register port widths.
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NUM_DIV = 5;

    // Register indices on the plain register port.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_IN_PRESCALE = 4'h1;
    localparam logic [3:0] REG_FB_PRESCALE = 4'h2;
    localparam logic [3:0] REG_LOCK_LEN = 4'h3;
    localparam logic [3:0] REG_OUT_DIV0 = 4'h4;
    localparam logic [3:0] REG_OUT_DIV4 = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;

    // Control register field positions.
    localparam int unsigned CTRL_BYPASS_BIT = 0;
    localparam int unsigned CTRL_FBIDX_LSB = 1;
    localparam int unsigned CTRL_FBIDX_MSB = 3;
    localparam int unsigned CTRL_RXMODE_LSB = 4;
    localparam int unsigned CTRL_RXMODE_MSB = 7;

    // Status register field positions.
    localparam int unsigned STAT_LOCKED_BIT = 0;
    localparam int unsigned STAT_REFERENCE_PAIR_SELECT_BIT = 1;
    localparam int unsigned STAT_FBSEL_BIT = 2;
    localparam int unsigned STAT_BYPASS_BIT = 3;

    // Divider ranges.
    localparam logic [8:0] PRE_MIN = 9'h001;
    localparam logic [8:0] PRE_MAX = 9'h028;
    localparam logic [8:0] OUT_MIN = 9'h002;
    localparam logic [8:0] OUT_MAX = 9'h050;
    localparam logic [8:0] LOCK_MIN = 9'h010;
    localparam logic [8:0] LOCK_MAX = 9'h100;
    localparam logic [8:0] FBIDX_MAX = 9'h004;

    // Reset values.
    localparam logic [5:0] PRE_RST = 6'h01;
    localparam logic [6:0] OUT_RST = 7'h02;
    localparam logic [8:0] LOCK_RST = 9'h010;
    localparam logic [2:0] FBIDX_RST = 3'h0;

    // Positions of the pin inputs inside the synchroniser vector.
    localparam int unsigned SYN_W = 7;
    localparam int unsigned SYN_REF0 = 0;
    localparam int unsigned SYN_REF1 = 1;
    localparam int unsigned SYN_FB0 = 2;
    localparam int unsigned SYN_FB1 = 3;
    localparam int unsigned SYN_VCO = 4;
    localparam int unsigned SYN_REFERENCE_PAIR_SELECT = 5;
    localparam int unsigned SYN_FBSEL = 6;

    // Input receiver modes; 1.8 V CMOS has its own code because its thresholds differ.
    typedef enum logic [3:0] {
        PDS_RX_LVTTL33 = 4'h0,
        PDS_RX_LVCMOS18 = 4'h1,
        PDS_RX_LVCMOS25 = 4'h2,
        PDS_RX_LVCMOS33 = 4'h3,
        PDS_RX_SSTL_HSTL = 4'h4,
        PDS_RX_DIFF_SSTL_HSTL = 4'h5,
        PDS_RX_LVDS = 4'h6,
        PDS_RX_LVPECL = 4'h7
    } pds_rx_mode_t;

    // Limits a written value to an inclusive range.
    function automatic logic [8:0] clamp_range(input logic [15:0] v, input logic [8:0] lo,
                                               input logic [8:0] hi);
        if (v < {7'h00, lo}) begin
            return lo;
        end
        if (v > {7'h00, hi}) begin
            return hi;
        end
        return v[8:0];
    endfunction

endpackage

// ===== src/pds_divider.sv
// Counting divider: a pulse every limit input ticks and a square wave toggling on that pulse.
module pds_divider (
    // Clock and control.
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Count input.
    input wire logic tick,
    input wire logic [5:0] limit,
    // Results.
    output logic pulse,
    output logic level
);

    typedef struct packed {
        logic [5:0] cnt;
        logic pulse;
        logic level;
    } pds_div_state_t;

    pds_div_state_t q;
    pds_div_state_t d;

    // Terminal count toggles the level, so an even overall ratio gives an even duty cycle.
    always_comb begin
        d = q;
        d.pulse = 1'b0;
        if (tick) begin
            if (q.cnt + 6'h01 >= limit) begin
                d.cnt = 6'h00;
                d.pulse = 1'b1;
                d.level = ~q.level;
            end else begin
                d.cnt = q.cnt + 6'h01;
            end
        end
    end

    // All divider state in one register.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign pulse = q.pulse;
    assign level = q.level;

    // The square wave only ever changes together with the terminal pulse.
    chk_level_on_pulse: assert property (@(posedge clk) disable iff (!resetn)
        (q.level != $past(q.level)) |-> q.pulse)
        else $error("divider level moved without pulse");

endmodule

// ===== src/pds_clock_control.sv
// PLL frequency plan control: prescalers, five output dividers, feedback choice, bypass, lock.
//
// Contract
// - Every output divider takes any even ratio from 2 to 80 on its own.
// - Locked and not bypassed, output k runs at ref times N times Vfbk over M times Vk.
// - Any output divider may close the feedback loop, even one that also drives an output.
// - With bypass high the input prescaler output feeds all output dividers directly.
// - In bypass each output ratio acts as half its setting, so output is 2 ref over M Vk.
// - In bypass there is no lock detection and no skew generation.
// - The reference select pin picks the first reference pair at 0, the second at 1.
// - The feedback select pin picks the first feedback pair at 0, the second at 1.
// - The receiver mode has its own code for 1.8 V CMOS input.
// - The input prescaler takes any integer ratio from 1 to 40.
// - The feedback prescaler takes any integer ratio from 1 to 40.
// - Active-low lock asserts after 16 to 256 good compare cycles and drops at once on loss.
module pds_clock_control (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Register port.
    input wire logic [pds_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pds_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pds_pkg::DATA_W-1:0] reg_rdata,
    // Reference and feedback receivers and oscillator tap.
    input wire logic first_reference_pair,
    input wire logic second_reference_pair,
    input wire logic first_feedback_pair,
    input wire logic second_feedback_pair,
    input wire logic vco_tap,
    // Input pair selector pins.
    input wire logic reference_pair_select,
    input wire logic feedback_pair_select,
    // Divided clocks.
    output logic [pds_pkg::NUM_DIV-1:0] out_clk,
    output logic feedback_clk_out,
    // Loop status and analog controls.
    output logic lock_n,
    output logic pump_up,
    output logic pump_dn,
    output logic skew_enable,
    output logic [3:0] rx_mode,
    output logic ref_pair_active,
    output logic fb_pair_active
);

    typedef struct packed {
        logic [pds_pkg::SYN_W-1:0] s1;
        logic [pds_pkg::SYN_W-1:0] s2;
        logic [pds_pkg::SYN_W-1:0] s3;
        logic bypass;
        logic [2:0] fb_idx;
        logic [3:0] rx_mode;
        logic [5:0] m_ratio;
        logic [5:0] n_ratio;
        logic [8:0] lock_len;
        logic [pds_pkg::NUM_DIV-1:0][6:0] v_ratio;
        logic [pds_pkg::DATA_W-1:0] rd_data;
        logic [pds_pkg::NUM_DIV-1:0] out_clk;
        logic fb_clk;
        logic [1:0] n_since;
        logic [8:0] lock_cnt;
        logic locked;
        logic lock_n;
        logic pump_up;
        logic pump_dn;
        logic skew_en;
        logic ref_sel;
        logic fb_sel;
    } pds_state_t;

    pds_state_t q;
    pds_state_t d;

    logic [pds_pkg::SYN_W-1:0] edge_seen;
    logic ref_tick;
    logic fb_tick;
    logic v_tick;
    logic m_pulse;
    logic n_pulse;
    logic [pds_pkg::NUM_DIV-1:0] v_level;
    logic [1:0] n_eff;
    logic [2:0] wr_idx;

    // Edges are taken on the second and third stages; the first stage feeds only the second.
    assign edge_seen = q.s2 ^ q.s3;
    assign ref_tick = q.s2[pds_pkg::SYN_REFERENCE_PAIR_SELECT] ? edge_seen[pds_pkg::SYN_REF1] :
                      edge_seen[pds_pkg::SYN_REF0];
    assign fb_tick = q.s2[pds_pkg::SYN_FBSEL] ? edge_seen[pds_pkg::SYN_FB1] :
                     edge_seen[pds_pkg::SYN_FB0];
    // Bypass steers the prescaled reference into the output dividers instead of the oscillator.
    assign v_tick = q.bypass ? m_pulse : edge_seen[pds_pkg::SYN_VCO];
    assign n_eff = q.n_since + {1'b0, n_pulse};
    assign wr_idx = 3'(reg_addr - pds_pkg::REG_OUT_DIV0);

    // Input prescaler counts both reference edges, so its pulse rate is twice ref over M.
    pds_divider u_in_prescale (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .tick(ref_tick),
        .limit(q.m_ratio),
        .pulse(m_pulse),
        .level()
    );

    // Feedback prescaler counts both edges of the returned feedback clock.
    pds_divider u_fb_prescale (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .tick(fb_tick),
        .limit(q.n_ratio),
        .pulse(n_pulse),
        .level()
    );

    // Output dividers toggle every half ratio ticks; with doubled bypass ticks the ratio halves.
    for (genvar k = 0; k < pds_pkg::NUM_DIV; k++) begin : g_out_div
        pds_divider u_out_div (
            .clk(clk),
            .resetn(resetn),
            .ce(ce),
            .tick(v_tick),
            .limit(q.v_ratio[k][6:1]),
            .pulse(),
            .level(v_level[k])
        );
    end

    // Next state: synchronisers, register port, clock outputs, lock detect and pump.
    always_comb begin
        d = q;
        d.s1 = {feedback_pair_select, reference_pair_select, vco_tap, second_feedback_pair,
                first_feedback_pair, second_reference_pair, first_reference_pair};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rd_data = '0;
        if (reg_wr) begin
            if (reg_addr == pds_pkg::REG_CTRL) begin
                d.bypass = reg_wdata[pds_pkg::CTRL_BYPASS_BIT];
                d.fb_idx = 3'(pds_pkg::clamp_range(
                    {13'h0000, reg_wdata[pds_pkg::CTRL_FBIDX_MSB:pds_pkg::CTRL_FBIDX_LSB]},
                    9'h000, pds_pkg::FBIDX_MAX));
                // Undefined receiver codes are ignored so the receiver never sees them.
                if (reg_wdata[pds_pkg::CTRL_RXMODE_MSB:pds_pkg::CTRL_RXMODE_LSB] <=
                    pds_pkg::PDS_RX_LVPECL) begin
                    d.rx_mode = reg_wdata[pds_pkg::CTRL_RXMODE_MSB:pds_pkg::CTRL_RXMODE_LSB];
                end
            end else if (reg_addr == pds_pkg::REG_IN_PRESCALE) begin
                d.m_ratio = 6'(pds_pkg::clamp_range(reg_wdata, pds_pkg::PRE_MIN,
                                                    pds_pkg::PRE_MAX));
            end else if (reg_addr == pds_pkg::REG_FB_PRESCALE) begin
                d.n_ratio = 6'(pds_pkg::clamp_range(reg_wdata, pds_pkg::PRE_MIN,
                                                    pds_pkg::PRE_MAX));
            end else if (reg_addr == pds_pkg::REG_LOCK_LEN) begin
                d.lock_len = pds_pkg::clamp_range(reg_wdata, pds_pkg::LOCK_MIN,
                                                  pds_pkg::LOCK_MAX);
            end else if (reg_addr >= pds_pkg::REG_OUT_DIV0 &&
                         reg_addr <= pds_pkg::REG_OUT_DIV4) begin
                // Odd requests round down to even so the duty cycle stays symmetric.
                d.v_ratio[wr_idx] = 7'(pds_pkg::clamp_range(reg_wdata, pds_pkg::OUT_MIN,
                                                            pds_pkg::OUT_MAX)) & 7'h7E;
            end
        end
        if (reg_rd) begin
            if (reg_addr == pds_pkg::REG_CTRL) begin
                d.rd_data = {8'h00, q.rx_mode, q.fb_idx, q.bypass};
            end else if (reg_addr == pds_pkg::REG_IN_PRESCALE) begin
                d.rd_data = {10'h000, q.m_ratio};
            end else if (reg_addr == pds_pkg::REG_FB_PRESCALE) begin
                d.rd_data = {10'h000, q.n_ratio};
            end else if (reg_addr == pds_pkg::REG_LOCK_LEN) begin
                d.rd_data = {7'h00, q.lock_len};
            end else if (reg_addr >= pds_pkg::REG_OUT_DIV0 &&
                         reg_addr <= pds_pkg::REG_OUT_DIV4) begin
                d.rd_data = {9'h000, q.v_ratio[wr_idx]};
            end else if (reg_addr == pds_pkg::REG_STATUS) begin
                d.rd_data = {12'h000, q.bypass, q.fb_sel, q.ref_sel, q.locked};
            end
        end
        // Output clocks and the loop-closing clock are registered copies of the divider waves.
        d.out_clk = v_level;
        d.fb_clk = v_level[q.fb_idx];
        d.ref_sel = q.s2[pds_pkg::SYN_REFERENCE_PAIR_SELECT];
        d.fb_sel = q.s2[pds_pkg::SYN_FBSEL];
        d.skew_en = ~q.bypass;
        if (q.bypass) begin
            // Without the loop there is nothing to compare, so lock and pump are held off.
            d.locked = 1'b0;
            d.lock_cnt = 9'h000;
            d.n_since = 2'h0;
            d.pump_up = 1'b0;
            d.pump_dn = 1'b0;
        end else begin
            if (m_pulse) begin
                d.n_since = 2'h0;
                if (n_eff == 2'h1) begin
                    if (q.lock_cnt < q.lock_len) begin
                        d.lock_cnt = q.lock_cnt + 9'h001;
                    end
                end else begin
                    d.lock_cnt = 9'h000;
                    d.locked = 1'b0;
                end
            end else if (n_pulse) begin
                d.n_since = (q.n_since == 2'h3) ? 2'h3 : q.n_since + 2'h1;
                // Two feedback pulses in one reference slot is a frequency error at once.
                if (n_eff >= 2'h2) begin
                    d.lock_cnt = 9'h000;
                    d.locked = 1'b0;
                end
            end
            if (d.lock_cnt >= q.lock_len) begin
                d.locked = 1'b1;
            end
            // Pump steers the oscillator; a pulse on one side cancels a pending one on the other.
            if (m_pulse && !n_pulse) begin
                d.pump_up = ~q.pump_dn;
                d.pump_dn = 1'b0;
            end else if (n_pulse && !m_pulse) begin
                d.pump_dn = ~q.pump_up;
                d.pump_up = 1'b0;
            end
        end
        d.lock_n = ~d.locked;
    end

    // All state in one register; the clock enable freezes everything.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
            q.m_ratio <= pds_pkg::PRE_RST;
            q.n_ratio <= pds_pkg::PRE_RST;
            q.lock_len <= pds_pkg::LOCK_RST;
            q.v_ratio <= {pds_pkg::NUM_DIV{pds_pkg::OUT_RST}};
            q.fb_idx <= pds_pkg::FBIDX_RST;
            q.rx_mode <= pds_pkg::PDS_RX_LVCMOS33;
            q.lock_n <= 1'b1;
            q.skew_en <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    // Every output is a field of the state register.
    assign reg_rdata = q.rd_data;
    assign out_clk = q.out_clk;
    assign feedback_clk_out = q.fb_clk;
    assign lock_n = q.lock_n;
    assign pump_up = q.pump_up;
    assign pump_dn = q.pump_dn;
    assign skew_enable = q.skew_en;
    assign rx_mode = q.rx_mode;
    assign ref_pair_active = q.ref_sel;
    assign fb_pair_active = q.fb_sel;

    // Checks on the stored plan and on the loop status.
    chk_out_ratio_even: assert property (@(posedge clk) disable iff (!resetn)
        ce && reg_wr && reg_addr == pds_pkg::REG_OUT_DIV0 |=>
        q.v_ratio[0][0] == 1'b0 && q.v_ratio[0] >= 7'h02 && q.v_ratio[0] <= 7'h50)
        else $error("output ratio not even in range");
    chk_prescale_range: assert property (@(posedge clk) disable iff (!resetn)
        q.m_ratio >= 6'h01 && q.m_ratio <= 6'h28 && q.n_ratio >= 6'h01 &&
        q.n_ratio <= 6'h28)
        else $error("prescale ratio out of range");
    // The wave was picked with last cycle's index; a control write may have moved it since.
    chk_fb_route: assert property (@(posedge clk) disable iff (!resetn)
        ce |=> q.fb_clk == q.out_clk[$past(q.fb_idx)])
        else $error("feedback clock not from chosen divider");
    chk_bypass_feed: assert property (@(posedge clk) disable iff (!resetn)
        ce && q.bypass && !m_pulse |=> $stable(v_level))
        else $error("divider moved without prescaler pulse in bypass");
    chk_bypass_nolock: assert property (@(posedge clk) disable iff (!resetn)
        ce && q.bypass |=> q.lock_n && !q.skew_en)
        else $error("lock or skew active in bypass");
    chk_ref_select: assert property (@(posedge clk) disable iff (!resetn)
        ce ##1 ce |-> ref_pair_active == $past(q.s2[pds_pkg::SYN_REFERENCE_PAIR_SELECT], 1))
        else $error("reference pair select wrong");
    chk_fb_select: assert property (@(posedge clk) disable iff (!resetn)
        ce ##1 ce |-> fb_pair_active == $past(q.s2[pds_pkg::SYN_FBSEL], 1))
        else $error("feedback pair select wrong");
    chk_rx_cmos18: assert property (@(posedge clk) disable iff (!resetn)
        ce && reg_wr && reg_addr == pds_pkg::REG_CTRL &&
        reg_wdata[7:4] == pds_pkg::PDS_RX_LVCMOS18 |=> rx_mode == pds_pkg::PDS_RX_LVCMOS18)
        else $error("1.8 V receiver code not applied");
    chk_lock_after_count: assert property (@(posedge clk) disable iff (!resetn)
        $fell(lock_n) |-> q.lock_cnt >= q.lock_len && q.lock_len >= 9'h010)
        else $error("lock asserted before count");
    chk_lock_drop: assert property (@(posedge clk) disable iff (!resetn)
        ce && !q.bypass && m_pulse && n_eff != 2'h1 |=> lock_n)
        else $error("lock not dropped on loss");

    // Main scenarios.
    cov_locked: cover property (@(posedge clk) disable iff (!resetn) $fell(lock_n));
    cov_bypass_out: cover property (@(posedge clk) disable iff (!resetn)
        q.bypass && $rose(out_clk[0]));
    cov_fb_shared: cover property (@(posedge clk) disable iff (!resetn)
        q.fb_idx == 3'h4 && $rose(feedback_clk_out));
    cov_second_ref: cover property (@(posedge clk) disable iff (!resetn)
        ref_pair_active && $rose(out_clk[0]));

endmodule

// ===== tb/pds_partner.sv
// Far-side model: two reference sources, the oscillator tap and the board feedback trace.
module pds_partner (
    // Board trace carrying the block's feedback clock.
    input wire logic fb_trace,
    // Clocks towards the block.
    output logic ref_a,
    output logic ref_b,
    output logic fb_a,
    output logic fb_b,
    output logic vco
);
    timeunit 1ns;
    timeprecision 1ps;
    // Unrelated source rates, so a wrong pair choice shows in the output counts.
    initial begin
        ref_a = 1'b0;
        forever #400 ref_a = ~ref_a;
    end
    initial begin
        ref_b = 1'b0;
        forever #600 ref_b = ~ref_b;
    end
    // The oscillator runs at a fixed rate; the bench picks ratios that match it to the reference.
    initial begin
        vco = 1'b0;
        forever #100 vco = ~vco;
    end
    // The second feedback pair carries a stray clock that cannot hold the loop in lock.
    initial begin
        fb_b = 1'b0;
        forever #150 fb_b = ~fb_b;
    end
    // The first feedback pair sees the trace after a short board delay.
    assign #30 fb_a = fb_trace;
endmodule

// ===== tb/pds_clock_control_tb.sv
// Self-checking bench for the PLL divider and input select block.
module pds_clock_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic resetn;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic ce;
    logic [15:0] reg_rdata;
    logic ref_a, ref_b, fb_a, fb_b, vco, ref_sel, fb_sel, fb_out;
    logic lock_n, pump_up, pump_dn, skew_en, ref_act, fb_act, meas;
    logic [4:0] out_clk;
    logic [4:0] prev;
    logic [3:0] rx_mode;
    int fails;
    int n_compared;
    int tog[5];
    int hi[5];

    pds_partner far (.fb_trace(fb_out), .ref_a(ref_a), .ref_b(ref_b), .fb_a(fb_a), .fb_b(fb_b),
        .vco(vco));
    pds_clock_control DUT (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_reference_pair(ref_a), .second_reference_pair(ref_b),
        .first_feedback_pair(fb_a), .second_feedback_pair(fb_b), .vco_tap(vco),
        .reference_pair_select(ref_sel), .feedback_pair_select(fb_sel), .out_clk(out_clk),
        .feedback_clk_out(fb_out), .lock_n(lock_n), .pump_up(pump_up), .pump_dn(pump_dn),
        .skew_enable(skew_en), .rx_mode(rx_mode), .ref_pair_active(ref_act),
        .fb_pair_active(fb_act));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Counts toggles and high cycles of every divided clock while a measurement runs.
    always @(posedge clk) begin
        prev <= out_clk;
        if (meas) begin
            for (int k = 0; k < 5; k++) begin
                tog[k] += int'(out_clk[k] !== prev[k]);
                hi[k] += int'(out_clk[k] === 1'b1);
            end
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask

    // Ticks is how many events reach the dividers in the window; outputs toggle every v/2.
    // Window edges cut half periods, so counts get a tolerance of one toggle and one half.
    task automatic measure(input int w, input real ticks, input int v[5]);
        real e;
        for (int k = 0; k < 5; k++) begin
            tog[k] = 0;
            hi[k] = 0;
        end
        @(posedge clk);
        meas <= 1'b1;
        repeat (w) @(posedge clk);
        meas <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            e = ticks * 2.0 / v[k];
            n_compared += 2;
            if (tog[k] < e - 1.5 || tog[k] > e + 1.5) begin
                fails++;
                $display("FAIL toggles of out_clk %0d expected %0.1f seen %0d", k, e, tog[k]);
            end
            if (hi[k] * 2.0 < w - 2.0 * w / e || hi[k] * 2.0 > w + 2.0 * w / e) begin
                fails++;
                $display("FAIL high cycles of out_clk %0d expected %0d seen %0d", k, w / 2, hi[k]);
            end
        end
    endtask

    // Boundary and out-of-range ratios, plus an unmapped index.
    task automatic t_ranges();
        logic [15:0] pw[3] = '{16'h0000, 16'h0028, 16'h0029};
        logic [15:0] pe[3] = '{16'h0001, 16'h0028, 16'h0028};
        logic [15:0] vw[3] = '{16'h0051, 16'h0007, 16'h0001};
        logic [15:0] ve[3] = '{16'h0050, 16'h0006, 16'h0002};
        rd(pds_pkg::REG_LOCK_LEN, 16'h0010, "lock length");
        wr(4'hA, 16'hFFFF);
        rd(4'hA, 16'h0000, "unmapped");
        for (int i = 0; i < 3; i++) begin
            wr(pds_pkg::REG_IN_PRESCALE, pw[i]);
            rd(pds_pkg::REG_IN_PRESCALE, pe[i], "input prescale");
            wr(pds_pkg::REG_FB_PRESCALE, pw[i]);
            rd(pds_pkg::REG_FB_PRESCALE, pe[i], "feedback prescale");
            for (int k = 0; k < 5; k++) begin
                wr(4'(pds_pkg::REG_OUT_DIV0 + k), vw[i]);
                rd(4'(pds_pkg::REG_OUT_DIV0 + k), ve[i], "output ratio");
            end
        end
    endtask

    // A strobe while the clock enable is low is lost, so the old setting must read back.
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        wr(pds_pkg::REG_LOCK_LEN, 16'h0020);
        ce <= 1'b1;
        rd(pds_pkg::REG_LOCK_LEN, 16'h0010, "lock length frozen");
    endtask

    // Every receiver code is kept and shown; an undefined code leaves the old one.
    task automatic t_rxmode();
        for (int c = 0; c < 8; c++) begin
            wr(pds_pkg::REG_CTRL, 16'(c << 4));
            rd(pds_pkg::REG_CTRL, 16'(c << 4), "control");
            check("rx_mode", 16'(c), 16'(rx_mode));
        end
        wr(pds_pkg::REG_CTRL, 16'h0090);
        rd(pds_pkg::REG_CTRL, 16'h0070, "control");
    endtask

    // Bypass with both reference pairs; the pair rates differ, so counts prove the choice.
    task automatic t_bypass();
        int vb[5] = '{2, 4, 6, 8, 10};
        wr(pds_pkg::REG_CTRL, 16'h0031);
        wr(pds_pkg::REG_IN_PRESCALE, 16'h0002);
        for (int k = 0; k < 5; k++) begin
            wr(4'(pds_pkg::REG_OUT_DIV0 + k), 16'(vb[k]));
        end
        for (int s = 0; s < 2; s++) begin
            ref_sel <= 1'(s);
            repeat (20) @(posedge clk);
            check("ref_pair_active", 16'(s), 16'(ref_act));
            rd(pds_pkg::REG_STATUS, 16'(8 + 2 * s), "status");
            measure(3200, 3200.0 / (s == 1 ? 12.0 : 8.0) / 2.0, vb);
            check("lock_n", 16'h0001, 16'(lock_n));
            check("skew_enable", 16'h0000, 16'(skew_en));
            check("pumps", 16'h0000, 16'({pump_up, pump_dn}));
        end
        ref_sel <= 1'b0;
    endtask

    // Loop closed through divider 2, which also drives an output; then the stray pair is chosen.
    task automatic t_lock();
        int vl[5] = '{2, 4, 4, 8, 10};
        wr(pds_pkg::REG_CTRL, 16'h0034);
        wr(pds_pkg::REG_IN_PRESCALE, 16'h0001);
        wr(pds_pkg::REG_FB_PRESCALE, 16'h0002);
        wr(pds_pkg::REG_LOCK_LEN, 16'h0010);
        for (int k = 0; k < 5; k++) begin
            wr(4'(pds_pkg::REG_OUT_DIV0 + k), 16'(vl[k]));
        end
        repeat (80) @(posedge clk);
        check("lock_n early", 16'h0001, 16'(lock_n));
        repeat (320) @(posedge clk);
        check("lock_n late", 16'h0000, 16'(lock_n));
        rd(pds_pkg::REG_STATUS, 16'h0001, "status");
        measure(3200, 3200.0 * 50.0 / 800.0 * 2.0 * 4.0 / 1.0, vl);
        fb_sel <= 1'b1;
        repeat (48) @(posedge clk);
        check("fb_pair_active", 16'h0001, 16'(fb_act));
        check("lock_n lost", 16'h0001, 16'(lock_n));
        fb_sel <= 1'b0;
    endtask

    // A hang is cut short well past the expected run of about 10300 cycles.
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        $display("FAIL watchdog expected finish seen timeout");
        final_report();
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ref_sel = 1'b0;
        fb_sel = 1'b0;
        meas = 1'b0;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        check("reset outputs", 16'h0066, 16'({out_clk, lock_n, skew_en, rx_mode, pump_up}));
        resetn <= 1'b1;
        t_ranges();
        t_freeze();
        t_rxmode();
        t_bypass();
        t_lock();
        final_report();
    end
endmodule
